// ==== design/clc_pkg.sv ====
// Shared constants and types for the configurable logic cell
package clc_pkg;

  // ****************************************
  // Input source selection codes
  // ****************************************
  localparam logic [1:0] CLC_SEL_PASS = 2'h0;   // Routed signal as received
  localparam logic [1:0] CLC_SEL_INV  = 2'h1;   // Routed signal inverted
  localparam logic [1:0] CLC_SEL_ZERO = 2'h2;   // Tied to logic zero
  localparam logic [1:0] CLC_SEL_ONE  = 2'h3;   // Tied to logic one
  localparam int         CLC_NUM_IN   = 4;      // General logic inputs
  localparam int         CLC_SEL_W    = 2;      // Width of one input selection

  // ****************************************
  // Cell operating modes, one-hot
  // ****************************************
  typedef enum logic [2:0] {
    CLC_MODE_COMB  = 3'h1,    // AND or pair merge gate
    CLC_MODE_LATCH = 3'h2,    // Single-cell transparent latch
    CLC_MODE_FLOP  = 3'h4     // Cascaded master and slave latches
  } clc_mode_t;

  // ****************************************
  // Values after reset
  // ****************************************
  localparam logic CLC_RST_OUT  = 1'h0;
  localparam logic CLC_RST_OE   = 1'h0;
  localparam logic CLC_RST_CASC = 1'h0;
  localparam logic CLC_RST_Q    = 1'h0;
  localparam logic CLC_RST_MQ   = 1'h0;

  // ****************************************
  // Registered cell state
  // ****************************************
  typedef struct packed {
    logic out;     // Logic output level
    logic oe;      // Output driver enable
    logic casc;    // Cascade output level
    logic q;       // Latch, or slave latch, value
    logic mq;      // Master latch value in flop mode
  } clc_state_t;

endpackage

// ==== design/clc_configurable_logic_cell.sv ====
// Configurable logic cell: gate, latch, flop or three-state driver
//
// Function
// [RULE1] Four logic inputs plus cascade in; one logic output plus cascade out.
// [RULE2] Each logic input independently used as received or inverted.
// [RULE3] Any logic input may be tied to constant zero or one instead.
// [RULE4] Inputs ANDed in two pairs, pairs merged by configurable OR or AND.
// [RULE5] Merge with input polarity gives two-input mux, XOR or XNOR.
// [RULE6] Enabled feedback turns the cell into a latch with data and gate.
// [RULE7] Latch follows data while gate active, holds value otherwise.
// [RULE8] Latch data and gate polarities each selectable active high or low.
// [RULE9] Two-cell latch adds a clear forcing zero regardless of gate; here the single-cell latch mode takes the clear too.
// [RULE10] Every latch also responds to the global reset network.
// [RULE11] Logic output has three-state control driven from one input.
// [RULE12] Cascade use is a static per-cell option like the others.
// [RULE13] Global reset clears only a holding latch, never a transparent one.
// [RULE14] Cascaded cells form an edge flop: master latch then slave latch.
// [RULE15] All configuration is static parameters fixed at build time.
module clc_configurable_logic_cell
  import clc_pkg::*;
#(
  parameter logic [7:0] IN_CFG      = 8'h00,  // Two bits per input, input 0 lowest
  parameter logic       MERGE_OR    = 1'h1,   // 1: OR merge, 0: AND merge
  parameter logic       FEEDBACK_EN = 1'h0,   // Internal feedback forms a latch
  parameter logic       CASCADE_EN  = 1'h0,   // Cascade connection in use
  parameter logic       TRI_EN      = 1'h0,   // Input 3 drives output enable
  parameter logic       D_ACT_HIGH  = 1'h1,   // Latch data polarity
  parameter logic       G_ACT_HIGH  = 1'h1,   // Latch gate polarity
  parameter logic       OE_ACT_HIGH = 1'h1    // Output enable polarity
) (
  // Clock, reset, enable
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic clk_en,
  // Logic and cascade inputs
  input  wire logic [3:0] logic_in,
  input  wire logic       cascade_in,
  // Latch control
  input  wire logic       async_clear_input,
  input  wire logic       global_reset,
  // Outputs
  output logic            cell_out,
  output logic            cell_out_oe,
  output logic            cascade_out
);

  // ****************************************
  // Static configuration decode
  // ****************************************
  // Mode is fixed at build time; nothing at run time can alter it
  localparam clc_mode_t MODE = !FEEDBACK_EN ? CLC_MODE_COMB :
                               (CASCADE_EN ? CLC_MODE_FLOP : CLC_MODE_LATCH); // [RULE15] [RULE12]

  // Level-sensitive storage step: clear beats everything, reset only when holding
  function automatic logic latch_step(input logic q, input logic d, input logic g,
                                      input logic clr, input logic grst);
    logic r;
    r = q;
    if (clr) begin
      r = 1'h0;                       // [RULE9]
    end else if (g) begin
      r = d;                          // [RULE7] [RULE13]
    end else if (grst) begin
      r = 1'h0;                       // [RULE10] [RULE13]
    end
    return r;
  endfunction

  // ****************************************
  // Reset synchroniser
  // ****************************************
  logic rst_meta_ff;
  logic rst_sync_ff;

  // Release is aligned to the clock so all state leaves reset on one edge
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_ff <= 1'h0;
      rst_sync_ff <= 1'h0;
    end else begin
      rst_meta_ff <= 1'h1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ****************************************
  // Input conditioning
  // ****************************************
  logic [3:0] sel_in;

  // One selection decode shared by all inputs
  function automatic logic cond_in(input logic [1:0] sel, input logic raw);
    logic r;
    r = raw;
    unique case (sel)
      CLC_SEL_PASS: r = raw;          // [RULE2]
      CLC_SEL_INV:  r = ~raw;         // [RULE2]
      CLC_SEL_ZERO: r = 1'h0;         // [RULE3]
      CLC_SEL_ONE:  r = 1'h1;         // [RULE3]
    endcase
    return r;
  endfunction

  // Free inversion or tie per input, so no cell is spent as an inverter
  for (genvar k = 0; k < CLC_NUM_IN; k++) begin : g_in
    localparam logic [1:0] SEL = IN_CFG[k*CLC_SEL_W +: CLC_SEL_W];
    assign sel_in[k] = cond_in(SEL, logic_in[k]);   // [RULE2] [RULE3]
  end

  // ****************************************
  // Combinational function and latch controls
  // ****************************************
  logic pair_lo;
  logic pair_hi;
  logic merged;
  logic d_act;
  logic g_act;
  logic oe_act;

  // Input 3 is spent on the enable when three-state is in use
  assign pair_lo = sel_in[0] & sel_in[1];                                   // [RULE4]
  assign pair_hi = TRI_EN ? sel_in[2] : (sel_in[2] & sel_in[3]);            // [RULE4]
  assign merged  = (MERGE_OR ? (pair_lo | pair_hi) : (pair_lo & pair_hi))
                   & (CASCADE_EN ? cascade_in : 1'h1);                      // [RULE4] [RULE5]
  assign d_act   = sel_in[0] ^ ~D_ACT_HIGH;                                 // [RULE8]
  assign g_act   = sel_in[1] ^ ~G_ACT_HIGH;                                 // [RULE8]
  assign oe_act  = TRI_EN ? (sel_in[3] ^ ~OE_ACT_HIGH) : 1'h1;              // [RULE11]

  // ****************************************
  // State update
  // ****************************************
  clc_state_t st_ff;
  clc_state_t nxt_st;

  // Clear acts only where a latch exists; plain gates ignore it
  always_comb begin
    nxt_st = st_ff;
    if (clk_en) begin
      nxt_st.oe = oe_act;                                                   // [RULE11]
      unique case (MODE)
        CLC_MODE_COMB: begin
          nxt_st.out  = merged;                                             // [RULE4]
          nxt_st.casc = CASCADE_EN ? pair_lo : 1'h0;                        // [RULE12]
        end
        CLC_MODE_LATCH: begin
          nxt_st.q    = latch_step(st_ff.q, d_act, g_act,
                                   async_clear_input, global_reset);        // [RULE6] [RULE7]
          nxt_st.out  = nxt_st.q;
          nxt_st.casc = 1'h0;
        end
        CLC_MODE_FLOP: begin
          // Master open while gate inactive, slave copies it while active
          nxt_st.mq   = latch_step(st_ff.mq, d_act, ~g_act,
                                   async_clear_input, global_reset);        // [RULE14]
          nxt_st.q    = latch_step(st_ff.q, st_ff.mq, g_act,
                                   async_clear_input, global_reset);        // [RULE14]
          nxt_st.out  = nxt_st.q;
          nxt_st.casc = nxt_st.mq;                                          // [RULE14]
        end
      endcase
    end
  end

  // Single register bank for all cell state
  always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      st_ff <= '{out: CLC_RST_OUT, oe: CLC_RST_OE, casc: CLC_RST_CASC,
                 q: CLC_RST_Q, mq: CLC_RST_MQ};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign cell_out    = st_ff.out;      // [RULE1]
  assign cell_out_oe = st_ff.oe;       // [RULE11]
  assign cascade_out = st_ff.casc;     // [RULE1]

  // ****************************************
  // Assertions
  // ****************************************
  logic comb_ref;
  // Independent restatement of the gate function for checking
  assign comb_ref = (MERGE_OR ? ((sel_in[0] & sel_in[1]) | (sel_in[2] & (TRI_EN | sel_in[3])))
                              : (sel_in[0] & sel_in[1] & sel_in[2] & (TRI_EN | sel_in[3])))
                    & (!CASCADE_EN | cascade_in);

  AST_COMB_FUNC: assert property ( // [RULE4]
    @(posedge sys_clk) disable iff (!rst_sync_ff)
    (MODE == CLC_MODE_COMB) && clk_en |=> cell_out == $past(comb_ref))
    else $error("gate output does not match pair merge");

  AST_FREEZE: assert property ( // [RULE15]
    @(posedge sys_clk) disable iff (!rst_sync_ff)
    !clk_en |=> $stable(cell_out) && $stable(cell_out_oe) && $stable(cascade_out))
    else $error("state moved while clock enable low");

  AST_LATCH_FOLLOW: assert property ( // [RULE7]
    @(posedge sys_clk) disable iff (!rst_sync_ff)
    (MODE == CLC_MODE_LATCH) && clk_en && g_act && !async_clear_input
    |=> cell_out == $past(d_act))
    else $error("transparent latch did not follow data");

  AST_LATCH_HOLD: assert property ( // [RULE7]
    @(posedge sys_clk) disable iff (!rst_sync_ff)
    (MODE == CLC_MODE_LATCH) && clk_en && !g_act && !async_clear_input && !global_reset
    |=> $stable(cell_out))
    else $error("closed latch changed value");

  AST_CLEAR: assert property ( // [RULE9]
    @(posedge sys_clk) disable iff (!rst_sync_ff)
    (MODE != CLC_MODE_COMB) && clk_en && async_clear_input ##1 clk_en && async_clear_input
    |=> !cell_out && !cascade_out)
    else $error("clear did not force zero");

  AST_GRST_HOLDING: assert property ( // [RULE13]
    @(posedge sys_clk) disable iff (!rst_sync_ff)
    (MODE == CLC_MODE_LATCH) && clk_en && !g_act && global_reset |=> !cell_out)
    else $error("global reset missed a holding latch");

  AST_GRST_TRANSP: assert property ( // [RULE13]
    @(posedge sys_clk) disable iff (!rst_sync_ff)
    (MODE == CLC_MODE_LATCH) && clk_en && g_act && global_reset && !async_clear_input
    |=> cell_out == $past(d_act))
    else $error("global reset disturbed a transparent latch");

  AST_FLOP_SLAVE_HOLD: assert property ( // [RULE14]
    @(posedge sys_clk) disable iff (!rst_sync_ff)
    (MODE == CLC_MODE_FLOP) && clk_en && !g_act && !async_clear_input && !global_reset
    |=> $stable(cell_out))
    else $error("slave latch moved while gate inactive");

  AST_FLOP_CAPTURE: assert property ( // [RULE14]
    @(posedge sys_clk) disable iff (!rst_sync_ff)
    (MODE == CLC_MODE_FLOP) && clk_en && !g_act && !async_clear_input
    ##1 clk_en && g_act && !async_clear_input
    |=> cell_out == $past(cascade_out))
    else $error("flop did not pass master value on gate edge");

  AST_OE: assert property ( // [RULE11]
    @(posedge sys_clk) disable iff (!rst_sync_ff)
    clk_en |=> cell_out_oe == (TRI_EN ? $past(sel_in[3] ^ ~OE_ACT_HIGH) : 1'h1))
    else $error("output enable wrong");

endmodule

// ==== sim/clc_nbr_model.sv ====
// Neighbour cell and routed wire model around the cell under test
module clc_nbr_model (
  // Clock
  input  wire logic sys_clk,
  // Neighbour cascade source and cell output
  input  wire logic nbr_casc,
  input  wire logic cell_out,
  input  wire logic cell_out_oe,
  // Toward the cell and the routed wire
  output logic      cascade_in,
  output logic      bus_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_ff;
  // Neighbour cascade output feeds our cascade input directly
  assign cascade_in = nbr_casc;
  // Released wire shows the inverse of the last level, so a stale value never passes
  always_ff @(posedge sys_clk) begin
    if (cell_out_oe) last_ff <= cell_out;
  end
  assign bus_line = cell_out_oe ? cell_out : ~last_ff;
endmodule

// ==== sim/tb.sv ====
// Self-checking bench for the configurable logic cell
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Cell setups: [15:8] input select, 6 or, 5 feedback, 4 cascade, 3 tri, 2 d, 1 g, 0 oe
  // ****************************************
  // 0 gate, 1 and+tie, 2 cascade, 3 xor, 4 latch, 5 low latch, 6 flop, 7 tri low-enable
  localparam logic [15:0] CFG [8] = '{16'h0046, 16'hC106, 16'h0056, 16'h1446,
                                      16'h0066, 16'h0060, 16'h0076, 16'h004E};
  // Rows: [9:6] inputs, 5 cascade in, [4:0] gate, and, casc out, casc pair, xor
  localparam logic [9:0] ROWS [8] = '{10'h020, 10'h0F6, 10'h334, 10'h3D2,
                                      10'h1A8, 10'h161, 10'h2A1, 10'h1F6};
  logic       sys_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       clk_en = 1'b0;
  logic [3:0] logic_in = 4'h0;
  logic       nbr_casc = 1'b0;
  logic       async_clear_input = 1'b0;
  logic       global_reset = 1'b0;
  logic       cascade_in;
  logic       bus_line;
  logic [7:0] o;
  logic [7:0] oe;
  logic [7:0] co;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  int         cyc = 0;

  // 125 MHz clock
  always #4 sys_clk = ~sys_clk;

  // ****************************************
  // Cells under test and neighbour
  // ****************************************
  for (genvar i = 0; i < 8; i++) begin : g_cell
    clc_configurable_logic_cell #(
      .IN_CFG(CFG[i][15:8]), .MERGE_OR(CFG[i][6]), .FEEDBACK_EN(CFG[i][5]),
      .CASCADE_EN(CFG[i][4]), .TRI_EN(CFG[i][3]), .D_ACT_HIGH(CFG[i][2]),
      .G_ACT_HIGH(CFG[i][1]), .OE_ACT_HIGH(CFG[i][0])
    ) dut (.sys_clk, .rstn, .clk_en, .logic_in, .cascade_in, .async_clear_input,
      .global_reset, .cell_out(o[i]), .cell_out_oe(oe[i]), .cascade_out(co[i]));
  end
  clc_nbr_model u_nbr (.sys_clk, .nbr_casc, .cell_out(o[7]), .cell_out_oe(oe[7]),
    .cascade_in, .bus_line);

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic seen, input logic exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Drive one input set, then look after the edge that samples it
  task automatic apply(input logic [3:0] v, input logic c, g, x, en);
    @(posedge sys_clk);
    logic_in <= v;
    nbr_casc <= c;
    global_reset <= g;
    async_clear_input <= x;
    clk_en <= en;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard: whole run needs well under a hundred cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      results();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge sys_clk);
    chk(o[0], 1'b0);
    chk(oe[0], 1'b0);
    @(posedge sys_clk) rstn <= 1'b1;
    // Reset sync needs two edges before inputs take effect
    repeat (3) @(posedge sys_clk);
    for (int r = 0; r < 8; r++) begin
      apply(ROWS[r][9:6], ROWS[r][5], 1'b0, 1'b0, 1'b1);
      chk(o[0], ROWS[r][4]);
      chk(o[1], ROWS[r][3]);
      chk(o[2], ROWS[r][2]);
      chk(co[2], ROWS[r][1]);
      chk(o[3], ROWS[r][0]);
    end
    // Latch, low-polarity latch and flop share one gate/data sequence
    apply(4'h1, 1'b0, 1'b0, 1'b0, 1'b1);
    chk(o[5], 1'b0);
    chk(co[6], 1'b1);
    apply(4'h3, 1'b0, 1'b0, 1'b0, 1'b1);
    chk(o[4], 1'b1);
    chk(o[5], 1'b0);
    chk(o[6], 1'b1);
    apply(4'h0, 1'b0, 1'b0, 1'b0, 1'b1);
    chk(o[4], 1'b1);
    chk(o[5], 1'b1);
    chk(co[6], 1'b0);
    chk(o[6], 1'b1);
    apply(4'h2, 1'b0, 1'b1, 1'b0, 1'b1);
    chk(o[4], 1'b0);
    chk(o[5], 1'b0);
    apply(4'h3, 1'b0, 1'b1, 1'b0, 1'b1);
    chk(o[4], 1'b1);
    // Flop from a cleared slave: master loads first, slave takes it on the gate
    apply(4'h1, 1'b0, 1'b0, 1'b0, 1'b1);
    chk(co[6], 1'b1);
    chk(o[6], 1'b0);
    apply(4'h3, 1'b0, 1'b0, 1'b0, 1'b1);
    chk(o[6], 1'b1);
    apply(4'h3, 1'b0, 1'b0, 1'b1, 1'b1);
    chk(o[4], 1'b0);
    chk(o[6], 1'b0);
    chk(co[6], 1'b0);
    // Three-state driver with low enable; the frozen cycle would flip both if it moved
    apply(4'hC, 1'b0, 1'b0, 1'b0, 1'b1);
    chk(oe[7], 1'b0);
    chk(bus_line, 1'b0);
    apply(4'h4, 1'b0, 1'b0, 1'b0, 1'b1);
    chk(oe[7], 1'b1);
    chk(bus_line, 1'b1);
    apply(4'hB, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(o[0], 1'b0);
    chk(oe[7], 1'b1);
    apply(4'hC, 1'b0, 1'b0, 1'b0, 1'b1);
    chk(oe[7], 1'b0);
    chk(bus_line, 1'b0);
    results();
  end
endmodule
